// [core/iod_port_decode.sv]
// i/o port decoder with system-select port and interrupt vectoring
// ----------------------------------------------------------------
// Functional notes
// - device index comes from address lines 2, 3, 4 and 7 only
// - selects only assert while the i/o chip select is active
// - at most one device select is high in any cycle
// - address bits 0 and 1 pass on as function within the device
// - transfer direction follows the processor read/write line
// - eight devices take consecutive four-port ranges from 00 to 1F
// - disk takes ports 08-0B; port 08 splits read/write, five logical ports
// - port 04 baud A, 05 baud B, 06 motor speed unimplemented
// - system-select port also uses address lines 1, 3 and timing enable
// - all eight port A lines drive the bank-select outputs
// - port B bits 0-5 are outputs, bits 6-7 modem inputs
// - control lines carry dma, keyboard, clock irqs and 50/60 select
// - clock select outputs choose internal generator or attached device
// - on acknowledge a one-byte vector is driven as handler low byte
// - serial vector takes one of 8 values by channel and cause
// - last serial vector is readable through serial read register 2
// ----------------------------------------------------------------
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module iod_port_decode #(
    parameter int unsigned NUM_DEV = iod_pkg::NUM_DEV
) (
    // clock and reset
    input  wire logic                clk_unused_n,
    input  wire logic                pclk,
    input  wire logic                presetn,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    // processor port cycle
    input  wire logic                io_cs_n,
    input  wire logic                io_rd,
    input  wire logic [7:0]          cpu_addr,
    input  wire logic [7:0]          cpu_wdata,
    output logic [7:0]               cpu_rdata,
    output logic                     cpu_rdata_oe,
    // interrupt acknowledge
    input  wire logic                int_ack,
    input  wire logic                sio_irq_pend,
    input  wire logic [2:0]          sio_irq_cause,
    // device selects
    output logic [NUM_DEV-1:0]       dev_sel,
    output logic [1:0]               dev_fn,
    output logic                     dev_rd,
    output logic                     dev_wr,
    output logic [1:0]               syssel_rs,
    output logic                     baud_a_sel,
    output logic                     baud_b_sel,
    output logic [iod_pkg::DISK_LPORTS-1:0] disk_lport,
    input  wire logic                timing_en,
    // system-select port lines
    output logic [7:0]               bank_line,
    output logic                     density_select_out,
    output logic                     drive_a_select_out,
    output logic                     drive_b_select_out,
    output logic                     speaker_out,
    output logic                     rx_clock_select_out,
    output logic                     tx_clock_select_out,
    input  wire logic                modem_ready_in,
    input  wire logic                modem_ring_in,
    input  wire logic                dma_irq_line,
    input  wire logic                keyboard_irq_line,
    input  wire logic                clock_tick_irq_line,
    output logic                     line_freq_select_out
);

    // ----------------------------------------------------------------
    // cycle capture and decode
    // ----------------------------------------------------------------
    iod_pkg::iod_cyc_t  cyc;
    logic [2:0]         dev_idx;
    logic               addr_hit;
    logic               dec_en;
    logic [1:0]         ctrl_q, ctrl_d;

    always_comb begin
        cyc.active = ~io_cs_n;
        cyc.rd     = io_rd;
        cyc.addr   = cpu_addr;
        cyc.wdata  = cpu_wdata;
    end

    assign dev_idx  = cyc.addr[iod_pkg::ADDR_DEV_MSB:iod_pkg::ADDR_DEV_LSB];
    assign dec_en   = ctrl_q[0];
    // lines 5 and 6 are not decoded, so 20-7F alias below 20
    assign addr_hit = cyc.active & dec_en & ~cyc.addr[iod_pkg::ADDR_HIGH];

    // ----------------------------------------------------------------
    // select registers
    // ----------------------------------------------------------------
    logic [NUM_DEV-1:0]              sel_q, sel_d;
    logic [1:0]                      fn_q, fn_d;
    logic                            rd_q, rd_d, wr_q, wr_d;
    logic [1:0]                      rs_q, rs_d;
    logic                            ba_q, ba_d, bb_q, bb_d;
    logic [iod_pkg::DISK_LPORTS-1:0] dl_q, dl_d;

    always_comb begin
        sel_d = '0;
        fn_d  = cyc.addr[1:0];
        rd_d  = addr_hit & cyc.rd;
        wr_d  = addr_hit & ~cyc.rd;
        rs_d  = {cyc.addr[iod_pkg::ADDR_PIA_B], cyc.addr[iod_pkg::ADDR_PIA_A]};
        ba_d  = 1'b0;
        bb_d  = 1'b0;
        dl_d  = '0;
        if (addr_hit) begin
            sel_d = NUM_DEV'(1) << dev_idx;
            // the system-select port only answers when the timing circuit allows
            if (dev_idx == iod_pkg::DEV_SYSSEL && !timing_en) begin
                sel_d = '0;
            end
            if (dev_idx == iod_pkg::DEV_TIMER) begin
                ba_d = (cyc.addr[1:0] == iod_pkg::FN_BAUD_A);
                bb_d = (cyc.addr[1:0] == iod_pkg::FN_BAUD_B);
            end
            if (dev_idx == iod_pkg::DEV_DISK) begin
                // port 08 reaches one register on read, another on write
                if (cyc.addr[1:0] == 2'h0) begin
                    dl_d = cyc.rd ? 5'h01 : 5'h02;
                end else begin
                    dl_d = 5'h01 << (3'(cyc.addr[1:0]) + 3'h1);
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q <= '0;
            fn_q  <= '0;
            rd_q  <= 1'b0;
            wr_q  <= 1'b0;
            rs_q  <= '0;
            ba_q  <= 1'b0;
            bb_q  <= 1'b0;
            dl_q  <= '0;
        end else begin
            sel_q <= sel_d;
            fn_q  <= fn_d;
            rd_q  <= rd_d;
            wr_q  <= wr_d;
            rs_q  <= rs_d;
            ba_q  <= ba_d;
            bb_q  <= bb_d;
            dl_q  <= dl_d;
        end
    end

    assign dev_sel    = sel_q;
    assign dev_fn     = fn_q;
    assign dev_rd     = rd_q;
    assign dev_wr     = wr_q;
    assign syssel_rs  = rs_q;
    assign baud_a_sel = ba_q;
    assign baud_b_sel = bb_q;
    assign disk_lport = dl_q;

    // ----------------------------------------------------------------
    // system-select port registers and vectors
    // ----------------------------------------------------------------
    logic                            sys_wr, sys_rd;
    logic [7:0]                      pa_q, pa_d;
    logic [iod_pkg::PB_OUT_BITS-1:0] pb_q, pb_d;
    logic                            lf_q, lf_d;
    logic [7:0]                      piavec_q, piavec_d;
    logic [7:0]                      siobase_q, siobase_d;
    logic [7:0]                      lastvec_q, lastvec_d;
    logic [7:0]                      ack_vec;
    logic                            pia_irq;
    logic                            sio_rr2_rd;

    assign sys_wr  = addr_hit & ~cyc.rd & timing_en & (dev_idx == iod_pkg::DEV_SYSSEL);
    assign sys_rd  = addr_hit & cyc.rd & timing_en & (dev_idx == iod_pkg::DEV_SYSSEL);
    assign pia_irq = dma_irq_line | keyboard_irq_line | clock_tick_irq_line;
    assign sio_rr2_rd = addr_hit & cyc.rd & (dev_idx == iod_pkg::DEV_SERIAL)
                      & (cyc.addr[1:0] == iod_pkg::FN_SIO_RR2);

    // status-affects-vector: cause lands in bits 3:1, eight distinct bytes
    assign ack_vec = sio_irq_pend ? {siobase_q[7:4], sio_irq_cause, 1'b0}
                                  : piavec_q;

    always_comb begin
        pa_d      = pa_q;
        pb_d      = pb_q;
        lf_d      = lf_q;
        piavec_d  = piavec_q;
        siobase_d = siobase_q;
        lastvec_d = lastvec_q;
        if (sys_wr) begin
            unique case (cyc.addr[1:0])
                iod_pkg::FN_PORT_A: pa_d     = cyc.wdata;
                iod_pkg::FN_PORT_B: pb_d     = cyc.wdata[iod_pkg::PB_OUT_BITS-1:0];
                iod_pkg::FN_CTRL:   lf_d     = cyc.wdata[0];
                iod_pkg::FN_VECTOR: piavec_d = cyc.wdata;
            endcase
        end
        if (psel && penable && pwrite && paddr == iod_pkg::OFS_SIOBASE) begin
            siobase_d = pwdata[7:0];
        end
        if (int_ack && sio_irq_pend) begin
            lastvec_d = ack_vec;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pa_q      <= iod_pkg::RST_BYTE;
            pb_q      <= '0;
            lf_q      <= 1'b0;
            piavec_q  <= iod_pkg::RST_PIAVEC;
            siobase_q <= iod_pkg::RST_SIOBASE;
            lastvec_q <= iod_pkg::RST_BYTE;
        end else begin
            pa_q      <= pa_d;
            pb_q      <= pb_d;
            lf_q      <= lf_d;
            piavec_q  <= piavec_d;
            siobase_q <= siobase_d;
            lastvec_q <= lastvec_d;
        end
    end

    assign bank_line            = pa_q;
    assign density_select_out   = pb_q[0];
    assign drive_a_select_out   = pb_q[1];
    assign drive_b_select_out   = pb_q[2];
    assign speaker_out          = pb_q[3];
    assign rx_clock_select_out  = pb_q[4];
    assign tx_clock_select_out  = pb_q[5];
    assign line_freq_select_out = lf_q;

    // ----------------------------------------------------------------
    // processor read data
    // ----------------------------------------------------------------
    logic [7:0] rdat_q, rdat_d;
    logic       roe_q, roe_d;

    always_comb begin
        rdat_d = '0;
        roe_d  = 1'b0;
        if (int_ack) begin
            rdat_d = ack_vec;
            roe_d  = sio_irq_pend | pia_irq;
        end else if (sio_rr2_rd) begin
            rdat_d = lastvec_q;
            roe_d  = 1'b1;
        end else if (sys_rd) begin
            roe_d = 1'b1;
            unique case (cyc.addr[1:0])
                iod_pkg::FN_PORT_A: rdat_d = pa_q;
                iod_pkg::FN_PORT_B: rdat_d = {modem_ring_in, modem_ready_in, pb_q};
                iod_pkg::FN_CTRL:   rdat_d = {4'h0, clock_tick_irq_line,
                                              keyboard_irq_line, dma_irq_line, lf_q};
                iod_pkg::FN_VECTOR: rdat_d = piavec_q;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdat_q <= '0;
            roe_q  <= 1'b0;
        end else begin
            rdat_q <= rdat_d;
            roe_q  <= roe_d;
        end
    end

    assign cpu_rdata    = rdat_q;
    assign cpu_rdata_oe = roe_q;

    // ----------------------------------------------------------------
    // apb slave, zero wait states
    // ----------------------------------------------------------------
    iod_pkg::iod_last_t last_q, last_d;
    logic [31:0]        prd_q, prd_d;
    logic               map_hit;

    assign map_hit = (paddr == iod_pkg::OFS_CTRL) || (paddr == iod_pkg::OFS_STATUS)
                  || (paddr == iod_pkg::OFS_SIOBASE) || (paddr == iod_pkg::OFS_LASTVEC);

    always_comb begin
        ctrl_d = ctrl_q;
        last_d = last_q;
        prd_d  = prd_q;
        if (addr_hit) begin
            last_d.valid = 1'b1;
            last_d.rd    = cyc.rd;
            last_d.dev   = dev_idx;
            last_d.fn    = cyc.addr[1:0];
        end
        if (psel && penable && pwrite && paddr == iod_pkg::OFS_CTRL) begin
            ctrl_d = pwdata[1:0];
        end
        if (psel && !penable) begin
            unique case (paddr)
                iod_pkg::OFS_CTRL:    prd_d = {30'h0, ctrl_q};
                iod_pkg::OFS_STATUS:  prd_d = {24'h0, sel_q};
                iod_pkg::OFS_SIOBASE: prd_d = {24'h0, siobase_q};
                iod_pkg::OFS_LASTVEC: prd_d = {16'h0, 1'b0, last_q, lastvec_q};
                default:              prd_d = '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= iod_pkg::RST_CTRL;
            last_q <= '0;
            prd_q  <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            last_q <= last_d;
            prd_q  <= prd_d;
        end
    end

    assign prdata  = prd_q;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~map_hit;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_onehot_sel;
        $onehot0(dev_sel);
    endproperty
    a_onehot_sel: assert property (p_onehot_sel) else $error("two selects at once");

    property p_no_cs_no_sel;
        io_cs_n |=> (dev_sel == '0) && !dev_rd && !dev_wr;
    endproperty
    a_no_cs_no_sel: assert property (p_no_cs_no_sel) else $error("select without cs");

    property p_sel_index;
        (addr_hit && cpu_addr[4:2] != iod_pkg::DEV_SYSSEL)
            |=> dev_sel[$past(cpu_addr[4:2])];
    endproperty
    a_sel_index: assert property (p_sel_index) else $error("wrong device select");

    property p_high_addr;
        (!io_cs_n && cpu_addr[7]) |=> dev_sel == '0 && !$past(roe_d);
    endproperty
    a_high_addr: assert property (p_high_addr) else $error("select above range");

    property p_fn_pass;
        addr_hit |=> dev_fn == $past(cpu_addr[1:0]);
    endproperty
    a_fn_pass: assert property (p_fn_pass) else $error("function bits lost");

    property p_dir;
        addr_hit |=> (dev_rd == $past(io_rd)) && (dev_wr != $past(io_rd));
    endproperty
    a_dir: assert property (p_dir) else $error("direction mismatch");

    property p_motor_quiet;
        (addr_hit && cpu_addr[4:0] == 5'h06) |=> !baud_a_sel && !baud_b_sel;
    endproperty
    a_motor_quiet: assert property (p_motor_quiet) else $error("motor port selected");

    property p_disk_split;
        (addr_hit && cpu_addr[4:0] == 5'h08)
            |=> disk_lport == ($past(io_rd) ? 5'h01 : 5'h02);
    endproperty
    a_disk_split: assert property (p_disk_split) else $error("disk port split wrong");

    property p_timing_gate;
        (addr_hit && cpu_addr[4:2] == 3'h0 && !timing_en) |=> !dev_sel[0];
    endproperty
    a_timing_gate: assert property (p_timing_gate) else $error("syssel without timing");

    property p_bank_write;
        (sys_wr && cpu_addr[1:0] == 2'h0) |=> bank_line == $past(cpu_wdata);
    endproperty
    a_bank_write: assert property (p_bank_write) else $error("bank lines not written");

    property p_ack_vec;
        (int_ack && sio_irq_pend)
            |=> cpu_rdata_oe && cpu_rdata[3:1] == $past(sio_irq_cause) && !cpu_rdata[0];
    endproperty
    a_ack_vec: assert property (p_ack_vec) else $error("bad serial vector");

    property p_rr2;
        (int_ack && sio_irq_pend) ##1 (!int_ack && sio_rr2_rd)
            |=> cpu_rdata == $past(ack_vec, 2);
    endproperty
    a_rr2: assert property (p_rr2) else $error("read register 2 stale");

endmodule : iod_port_decode

`default_nettype wire

// [pkg/iod_pkg.sv]
// constants and types for the i/o port decoder
`default_nettype none

package iod_pkg;

    // ----------------------------------------------------------------
    // device indices (address bits 4:2)
    // ----------------------------------------------------------------
    localparam int unsigned NUM_DEV      = 8;
    localparam logic [2:0]  DEV_SYSSEL   = 3'h0;
    localparam logic [2:0]  DEV_TIMER    = 3'h1;
    localparam logic [2:0]  DEV_DISK     = 3'h2;
    localparam logic [2:0]  DEV_SERIAL   = 3'h3;
    localparam logic [2:0]  DEV_PARPORT  = 3'h4;
    localparam logic [2:0]  DEV_KEYBOARD = 3'h5;
    localparam logic [2:0]  DEV_RTC      = 3'h6;
    localparam logic [2:0]  DEV_VIDEO    = 3'h7;

    // ----------------------------------------------------------------
    // address line positions
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_DEV_LSB = 2;
    localparam int unsigned ADDR_DEV_MSB = 4;
    localparam int unsigned ADDR_HIGH    = 7;
    localparam int unsigned ADDR_PIA_A   = 1;
    localparam int unsigned ADDR_PIA_B   = 3;

    // ----------------------------------------------------------------
    // functions inside a four-port range
    // ----------------------------------------------------------------
    localparam logic [1:0]  FN_PORT_A    = 2'h0;
    localparam logic [1:0]  FN_PORT_B    = 2'h1;
    localparam logic [1:0]  FN_CTRL      = 2'h2;
    localparam logic [1:0]  FN_VECTOR    = 2'h3;
    localparam logic [1:0]  FN_BAUD_A    = 2'h0;
    localparam logic [1:0]  FN_BAUD_B    = 2'h1;
    localparam logic [1:0]  FN_MOTOR     = 2'h2;
    localparam logic [1:0]  FN_SIO_RR2   = 2'h2;
    localparam int unsigned DISK_LPORTS  = 5;
    localparam int unsigned PB_OUT_BITS  = 6;

    // ----------------------------------------------------------------
    // apb register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_STATUS   = 8'h04;
    localparam logic [7:0]  OFS_SIOBASE  = 8'h08;
    localparam logic [7:0]  OFS_LASTVEC  = 8'h0C;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [1:0]  RST_CTRL     = 2'h1;
    localparam logic [7:0]  RST_SIOBASE  = 8'hE0;
    localparam logic [7:0]  RST_PIAVEC   = 8'hFE;
    localparam logic [7:0]  RST_BYTE     = 8'h00;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       active;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } iod_cyc_t;

    typedef struct packed {
        logic       valid;
        logic       rd;
        logic [2:0] dev;
        logic [1:0] fn;
    } iod_last_t;

endpackage : iod_pkg

`default_nettype wire

// [sim/iod_cpu_model.sv]
// processor model issuing port cycles and interrupt acknowledges
`timescale 1ns/1ps
`default_nettype none

module iod_cpu_model (
    // clock
    input  wire logic       pclk,
    // port cycle
    output logic            io_cs_n,
    output logic            io_rd,
    output logic [7:0]      cpu_addr,
    output logic [7:0]      cpu_wdata,
    output logic            int_ack
);
    initial begin
        io_cs_n   = 1'b1;
        io_rd     = 1'b1;
        cpu_addr  = 8'hFF;
        cpu_wdata = 8'h00;
        int_ack   = 1'b0;
    end

    // ----------------------------------------------------------------
    // port cycle, held until the next call, outputs checked just after the next edge
    // ----------------------------------------------------------------
    task cyc(input logic cs_n, input logic rd, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        io_cs_n   <= cs_n;
        io_rd     <= rd;
        cpu_addr  <= a;
        // data bus released on reads: keep toggling, never a stale value
        cpu_wdata <= rd ? ~cpu_wdata : d;
        int_ack   <= 1'b0;
        @(posedge pclk);
        #1;
    endtask : cyc

    task ack();
        @(posedge pclk);
        io_cs_n   <= 1'b1;
        int_ack   <= 1'b1;
        cpu_wdata <= ~cpu_wdata;
        @(posedge pclk);
        #1;
    endtask : ack

    // dispatch entry a handler would reach: dma, parallel, then serial by cause code
    function automatic logic [15:0] slot_addr(input logic [7:0] vec);
        logic [3:0] slot;
        slot = (vec[7:4] == 4'hF) ? 4'h1 : 4'(vec[3:1]) + 4'h2;
        return 16'h23F3 + 16'(slot) * 16'h0003;
    endfunction : slot_addr
endmodule : iod_cpu_model

`default_nettype wire

// [sim/tb_io_port_decode.sv]
// self-checking bench for the i/o port decoder
`timescale 1ns/1ps
`default_nettype none

module tb_io_port_decode_and_vectoring;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, timing_en;
    logic        io_cs_n, io_rd, int_ack, sio_irq_pend, cpu_rdata_oe, dev_rd, dev_wr;
    logic        modem_ready_in, modem_ring_in, dma_irq_line, keyboard_irq_line;
    logic        clock_tick_irq_line, line_freq_select_out, baud_a_sel, baud_b_sel;
    logic        dens, drva, drvb, spk, rxc, txc;
    logic [1:0]  dev_fn, syssel_rs;
    logic [2:0]  sio_irq_cause;
    logic [4:0]  disk_lport;
    logic [7:0]  paddr, cpu_addr, cpu_wdata, cpu_rdata, dev_sel, bank_line;
    logic [31:0] pwdata, prdata, r;
    logic        e;
    int          n_mismatch, checks, cyc_cnt;

    iod_cpu_model cpu (.pclk(pclk), .io_cs_n(io_cs_n), .io_rd(io_rd), .cpu_addr(cpu_addr),
        .cpu_wdata(cpu_wdata), .int_ack(int_ack));

    iod_port_decode uut (.clk_unused_n(1'b0), .pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .io_cs_n(io_cs_n), .io_rd(io_rd),
        .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
        .cpu_rdata_oe(cpu_rdata_oe), .int_ack(int_ack), .sio_irq_pend(sio_irq_pend),
        .sio_irq_cause(sio_irq_cause), .dev_sel(dev_sel), .dev_fn(dev_fn), .dev_rd(dev_rd),
        .dev_wr(dev_wr), .syssel_rs(syssel_rs), .baud_a_sel(baud_a_sel),
        .baud_b_sel(baud_b_sel), .disk_lport(disk_lport), .timing_en(timing_en),
        .bank_line(bank_line), .density_select_out(dens), .drive_a_select_out(drva),
        .drive_b_select_out(drvb), .speaker_out(spk), .rx_clock_select_out(rxc),
        .tx_clock_select_out(txc), .modem_ready_in(modem_ready_in),
        .modem_ring_in(modem_ring_in), .dma_irq_line(dma_irq_line),
        .keyboard_irq_line(keyboard_irq_line), .clock_tick_irq_line(clock_tick_irq_line),
        .line_freq_select_out(line_freq_select_out));

    always #20 pclk = ~pclk;

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task print_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk

    // setup, then access until pready; data and error taken at that edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // ----------------------------------------------------------------
    // hang guard
    // ----------------------------------------------------------------
    always @(posedge pclk) begin
        cyc_cnt++;
        if (cyc_cnt == 3000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {sio_irq_pend, sio_irq_cause, modem_ring_in, dma_irq_line} = '0;
        {keyboard_irq_line, clock_tick_irq_line, n_mismatch, checks, cyc_cnt} = '0;
        timing_en = 1'b1;
        modem_ready_in = 1'b1;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        #1;
        chk(dev_sel, 0); chk(cpu_rdata_oe, 0); chk(bank_line, 0); chk(pready, 1);
        apb(1'b0, iod_pkg::OFS_CTRL, 0); chk(r, iod_pkg::RST_CTRL);
        apb(1'b0, iod_pkg::OFS_SIOBASE, 0); chk(r, iod_pkg::RST_SIOBASE);
        apb(1'b0, 8'h10, 0); chk(e, 1); chk(r, 0);
        for (int d = 0; d < 8; d++) begin
            cpu.cyc(1'b0, 1'b1, 8'(d * 4 + d % 4), 8'h00);
            chk(dev_sel, 32'(1 << d)); chk(dev_fn, d % 4); chk({dev_rd, dev_wr}, 2);
        end
        cpu.cyc(1'b0, 1'b0, 8'h04, 8'h00); chk({baud_a_sel, baud_b_sel, dev_wr}, 5);
        cpu.cyc(1'b0, 1'b0, 8'h05, 8'h00); chk({baud_a_sel, baud_b_sel, dev_wr}, 3);
        cpu.cyc(1'b0, 1'b0, 8'h06, 8'h00); chk({baud_a_sel, baud_b_sel, dev_sel}, 2);
        cpu.cyc(1'b0, 1'b1, 8'h08, 8'h00); chk(disk_lport, 5'h01);
        cpu.cyc(1'b0, 1'b0, 8'h08, 8'h00); chk(disk_lport, 5'h02);
        cpu.cyc(1'b0, 1'b0, 8'h0B, 8'h00); chk(disk_lport, 5'h10);
        cpu.cyc(1'b0, 1'b1, 8'h84, 8'h00); chk({dev_sel, cpu_rdata_oe}, 0);
        cpu.cyc(1'b1, 1'b1, 8'h04, 8'h00); chk({dev_sel, cpu_rdata_oe}, 0);
        timing_en <= 1'b0;
        cpu.cyc(1'b0, 1'b0, 8'h02, 8'h00); chk(dev_sel, 0);
        timing_en <= 1'b1;
        cpu.cyc(1'b0, 1'b0, 8'h02, 8'h01); chk(syssel_rs, 2'h1);
        cpu.cyc(1'b0, 1'b0, 8'h00, 8'hA5); chk(bank_line, 8'hA5);
        cpu.cyc(1'b0, 1'b0, 8'h01, 8'h2A); chk({txc, rxc, spk, drvb, drva, dens}, 6'h2A);
        {modem_ring_in, modem_ready_in} <= 2'h2;
        cpu.cyc(1'b0, 1'b1, 8'h01, 8'h00); chk({cpu_rdata_oe, cpu_rdata}, 9'h1AA);
        chk(line_freq_select_out, 1);
        {dma_irq_line, keyboard_irq_line, clock_tick_irq_line} <= 3'h7;
        cpu.cyc(1'b0, 1'b1, 8'h02, 8'h00); chk(cpu_rdata, 8'h0F);
        cpu.cyc(1'b0, 1'b1, 8'h03, 8'h00);
        chk({cpu_rdata_oe, cpu_rdata}, {1'b1, iod_pkg::RST_PIAVEC});
        // disabled decoder refuses a read of port 04
        apb(1'b1, iod_pkg::OFS_CTRL, 0);
        cpu.cyc(1'b0, 1'b1, 8'h04, 8'h00); chk(dev_sel, 0);
        apb(1'b1, iod_pkg::OFS_CTRL, 1);
        sio_irq_pend <= 1'b1;
        sio_irq_cause <= 3'h3;
        cpu.ack(); chk({cpu_rdata_oe, cpu_rdata}, 9'h1E6);
        chk(cpu.slot_addr(cpu_rdata), 32'h2402);
        cpu.cyc(1'b0, 1'b1, 8'h0E, 8'h00); chk({cpu_rdata_oe, cpu_rdata}, 9'h1E6);
        apb(1'b0, iod_pkg::OFS_LASTVEC, 0); chk(r, 32'h00006EE6);
        apb(1'b0, iod_pkg::OFS_STATUS, 0); chk(r, 32'h08);
        sio_irq_pend <= 1'b0;
        cpu.ack(); chk({cpu_rdata_oe, cpu_rdata}, 9'h1FE);
        chk(cpu.slot_addr(cpu_rdata), 32'h23F6);
        {dma_irq_line, keyboard_irq_line, clock_tick_irq_line} <= 3'h0;
        cpu.cyc(1'b1, 1'b1, 8'h00, 8'h00);
        cpu.ack(); chk(cpu_rdata_oe, 0);
        cpu.cyc(1'b1, 1'b1, 8'h00, 8'h00);
        print_verdict();
    end
endmodule : tb_io_port_decode_and_vectoring

`default_nettype wire
